// *** design/can_state_pkg.sv ***
// Shared constants, state encodings and helper functions for the CAN state control block.
// Assumes a single 100 MHz clock and that every importer uses the same field layout.
package can_state_pkg;

  // Command byte layout: bit 0 switches CAN participation, bits 7..1 are reserved.
  localparam int          CTL_ON_BIT    = 0;
  localparam int          CTL_RSVD_MSB  = 7;
  localparam int          CTL_RSVD_LSB  = 1;

  // Status byte layout: bits 1..0 hold the controller state code, bits 7..2 are reserved.
  localparam int          STAT_CODE_MSB = 1;
  localparam int          STAT_CODE_LSB = 0;
  localparam int          STAT_RSVD_MSB = 7;
  localparam int          STAT_RSVD_LSB = 2;
  localparam logic [7:0]  STATUS_RESET  = 8'h00;

  // Controller state codes, most significant bit in the higher bit position.
  localparam logic [1:0]  CODE_OFF      = 2'h0;
  localparam logic [1:0]  CODE_BUS_OFF  = 2'h1;
  localparam logic [1:0]  CODE_PASSIVE  = 2'h2;
  localparam logic [1:0]  CODE_ACTIVE   = 2'h3;

  // Error counter width and the two limits applied to it.
  localparam int          ERR_CNT_W         = 9;
  localparam logic [8:0]  ERR_PASSIVE_LIMIT = 9'h080;
  localparam logic [8:0]  ERR_BUSOFF_LIMIT  = 9'h0ff;

  // Bus synchronisation must finish within this time or the controller goes bus off.
  localparam int          CLK_FREQ_HZ         = 100_000_000;
  localparam int          SYNC_TIME_MS        = 2000;
  localparam int          SYNC_TIMEOUT_CYCLES = SYNC_TIME_MS * (CLK_FREQ_HZ / 1000);

  // One-hot controller states.
  typedef enum logic [3:0] {
    ST_OFF  = 4'b0001,
    ST_SYNC = 4'b0010,
    ST_RUN  = 4'b0100,
    ST_BOFF = 4'b1000
  } ctl_state_t;

  // Maps the controller state and error count onto the reported code.
  function automatic logic [1:0] state_code_f(input ctl_state_t s, input logic [8:0] err);
    logic [1:0] code;
    code = CODE_ACTIVE;
    case (s)
      ST_OFF:  code = CODE_OFF;
      ST_BOFF: code = CODE_BUS_OFF;
      default: code = (err >= ERR_PASSIVE_LIMIT) ? CODE_PASSIVE : CODE_ACTIVE;
    endcase
    return code;
  endfunction : state_code_f

  // Builds the status byte; the reserved bits are always zero.
  function automatic logic [7:0] status_byte_f(input logic [1:0] code);
    return {6'h00, code};
  endfunction : status_byte_f

endpackage : can_state_pkg

// *** design/can_state_if.sv ***
// Carries the run request and CAN core health into the fault tracker, and its verdict back.
// Assumes both ends share the top module clock.
`timescale 1ns/1ns
interface can_state_if;
  import can_state_pkg::*;
  logic                 enable;
  logic [ERR_CNT_W-1:0] err_cnt;
  logic                 sync_done;
  logic                 can_link_ok;
  logic [1:0]           state_code;
  logic                 tx_allow;
  logic                 rx_allow;

  modport tracker (input enable, err_cnt, sync_done, can_link_ok,
                   output state_code, tx_allow, rx_allow);
  modport ctrl    (output enable, err_cnt, sync_done, can_link_ok,
                   input state_code, tx_allow, rx_allow);
endinterface : can_state_if

// *** design/can_fault_tracker.sv ***
// Controller state machine: off, synchronising, running, bus off.
// Assumes the error counter and sync indication come from the CAN core on the same clock.
`timescale 1ns/1ns
module can_fault_tracker
  import can_state_pkg::*;
#(
  parameter int unsigned SYNC_CYCLES = SYNC_TIMEOUT_CYCLES,
  parameter int          CNT_W       = 28
) (
  input  wire logic    i_ref_clk,
  input  wire logic    i_sys_rst,
  can_state_if.tracker st
);

  localparam logic [CNT_W-1:0] SYNC_LAST = CNT_W'(SYNC_CYCLES - 1);

  ctl_state_t       state_ff;
  logic [CNT_W-1:0] sync_cnt_ff;

  // Bus off is left only by switching the controller off, which is the recovery path.
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      state_ff <= ST_OFF;
    end else begin
      case (state_ff)
        ST_OFF: begin
          if (st.enable) state_ff <= ST_SYNC;
        end
        ST_SYNC: begin
          if (!st.enable) state_ff <= ST_OFF;
          else if (!st.can_link_ok || sync_cnt_ff == SYNC_LAST) state_ff <= ST_BOFF;
          else if (st.sync_done) state_ff <= ST_RUN;
        end
        ST_RUN: begin
          if (!st.enable) state_ff <= ST_OFF;
          else if (!st.can_link_ok || st.err_cnt > ERR_BUSOFF_LIMIT) state_ff <= ST_BOFF;
        end
        ST_BOFF: begin
          if (!st.enable) state_ff <= ST_OFF;
        end
        default: state_ff <= ST_OFF;
      endcase
    end
  end

  // Time spent synchronising; cleared whenever the controller is not in that phase.
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst || state_ff != ST_SYNC) sync_cnt_ff <= '0;
    else sync_cnt_ff <= sync_cnt_ff + 1'b1;
  end

  // Receive is needed while synchronising; transmit only once the bus is joined.
  assign st.state_code = state_code_f(state_ff, st.err_cnt);
  assign st.tx_allow   = (state_ff == ST_RUN);
  assign st.rx_allow   = (state_ff == ST_RUN) || (state_ff == ST_SYNC);

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);

  chk_sync_timeout: assert property (
    state_ff == ST_SYNC && st.enable && sync_cnt_ff == SYNC_LAST |=> state_ff == ST_BOFF)
    else $error("sync timeout did not force bus off");
  chk_err_busoff: assert property (
    state_ff == ST_RUN && st.enable && st.err_cnt > ERR_BUSOFF_LIMIT |=> state_ff == ST_BOFF)
    else $error("error count overflow did not force bus off");
  chk_link_busoff: assert property (
    state_ff == ST_RUN && st.enable && !st.can_link_ok |=> state_ff == ST_BOFF)
    else $error("CAN link loss did not force bus off");
  chk_passive_code: assert property (
    state_ff == ST_RUN && st.err_cnt >= ERR_PASSIVE_LIMIT |-> st.state_code == CODE_PASSIVE
      && st.tx_allow)
    else $error("error passive not reported or traffic stopped");

endmodule : can_fault_tracker

// *** design/can_gateway_state_control.sv ***
// Communication state control for the industrial-link to CAN gateway.
// Assumes the cyclic command byte, link flags and CAN core health are synchronous inputs.
//
// Operation
// - Command bit zero low puts the CAN controller off, no bus participation.
// - Command bit zero high turns the CAN controller on for bus participation.
// - One status byte returned per exchange; bits one-zero state code, rest reserved.
// - Code zero reported whenever the host commands CAN off.
// - Bus off, code one, on error overflow or synchronisation over two seconds.
// - In bus off neither transmit nor receive on the CAN bus.
// - Code two, error passive, at error threshold; traffic continues.
// - Code three, error active, while errors stay below threshold.
// - Multi-bit fields read with highest bit most significant.
// - Host link failure drops to unconfigured, idle until new configuration.
// - CAN link failure forces bus off, keeps last data, stays operable.
// - Built-in switch keeps forwarding traffic even in error states.
// - Command bit followed only with active exchange and good provider status.
// - Off state sends and receives nothing, error frames included.
`timescale 1ns/1ns
module can_gateway_state_control
  import can_state_pkg::*;
#(
  parameter int unsigned SYNC_CYCLES = SYNC_TIMEOUT_CYCLES
) (
  input  wire logic                 i_ref_clk,
  input  wire logic                 i_sys_rst,
  input  wire logic [7:0]           i_cmd_byte,
  input  wire logic                 i_cmd_valid,
  input  wire logic                 i_exchange_active,
  input  wire logic                 i_provider_good,
  input  wire logic                 i_host_link_ok,
  input  wire logic                 i_config_load,
  input  wire logic [ERR_CNT_W-1:0] i_err_cnt,
  input  wire logic                 i_sync_done,
  input  wire logic                 i_can_link_ok,
  output logic [7:0]                o_status_byte,
  output logic                      o_status_valid,
  output logic                      o_can_tx_en,
  output logic                      o_can_rx_en,
  output logic                      o_configured,
  output logic                      o_pgn_hold,
  output logic                      o_switch_fwd_en
);

  logic       configured_ff;
  logic       ctl_on_ff;
  logic [7:0] status_byte_ff;
  logic       status_valid_ff;
  logic       tx_en_ff;
  logic       rx_en_ff;
  logic       pgn_hold_ff;
  logic       switch_fwd_ff;
  logic       run_req;

  can_state_if st_if ();

  // Configuration is lost with the host link; a fresh load wins over a same-cycle loss.
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      configured_ff <= 1'b0;
    end else if (i_config_load) begin
      configured_ff <= 1'b1;
    end else if (!i_host_link_ok) begin
      configured_ff <= 1'b0;
    end
  end

  // Only bit zero is taken from each command; reserved bits never reach the logic.
  // Dropping the bit on configuration loss stops a stale "on" surviving a reconnect.
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      ctl_on_ff <= 1'b0;
    end else if (!configured_ff || !i_host_link_ok) begin
      ctl_on_ff <= 1'b0;
    end else if (i_cmd_valid) begin
      ctl_on_ff <= i_cmd_byte[CTL_ON_BIT];
    end
  end

  // The controller runs only when every host-side condition holds at once.
  assign run_req = configured_ff && i_host_link_ok && i_exchange_active
                   && i_provider_good && ctl_on_ff;

  // Hand the request and CAN core health to the tracker.
  assign st_if.enable      = run_req;
  assign st_if.err_cnt     = i_err_cnt;
  assign st_if.sync_done   = i_sync_done;
  assign st_if.can_link_ok = i_can_link_ok;

  can_fault_tracker #(
    .SYNC_CYCLES (SYNC_CYCLES)
  ) u_tracker (
    .i_ref_clk (i_ref_clk),
    .i_sys_rst (i_sys_rst),
    .st        (st_if.tracker)
  );

  // Status is refreshed every cycle so a reply always carries the current state.
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      status_byte_ff <= STATUS_RESET;
    end else begin
      status_byte_ff <= status_byte_f(st_if.state_code);
    end
  end

  // One reply pulse per command, one cycle after the command arrives.
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      status_valid_ff <= 1'b0;
    end else begin
      status_valid_ff <= i_cmd_valid;
    end
  end

  // Bus enables follow the tracker; off and bus off keep the transceiver silent.
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      tx_en_ff <= 1'b0;
      rx_en_ff <= 1'b0;
    end else begin
      tx_en_ff <= st_if.tx_allow;
      rx_en_ff <= st_if.rx_allow;
    end
  end

  // While bus off the parameter group data is frozen, not cleared, so the host still sees it.
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      pgn_hold_ff <= 1'b0;
    end else begin
      pgn_hold_ff <= (st_if.state_code == CODE_BUS_OFF);
    end
  end

  // The network switch is never gated by gateway faults, so the plant network stays up.
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      switch_fwd_ff <= 1'b1;
    end else begin
      switch_fwd_ff <= 1'b1;
    end
  end

  // Ports come straight from the flip-flops above.
  assign o_status_byte   = status_byte_ff;
  assign o_status_valid  = status_valid_ff;
  assign o_can_tx_en     = tx_en_ff;
  assign o_can_rx_en     = rx_en_ff;
  assign o_configured    = configured_ff;
  assign o_pgn_hold      = pgn_hold_ff;
  assign o_switch_fwd_en = switch_fwd_ff;

  // Checks on the port-level behaviour and on the latched command bit.
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);

  chk_off_code: assert property (
    !run_req |-> ##2 (o_status_byte[STAT_CODE_MSB:STAT_CODE_LSB] == CODE_OFF))
    else $error("off state not reported two cycles after run request fell");

  chk_off_silent: assert property (
    !run_req |-> ##2 (!o_can_tx_en && !o_can_rx_en))
    else $error("bus enables still high after switching off");

  chk_no_exchange: assert property (
    !i_exchange_active || !i_provider_good |-> ##2 (o_status_byte[1:0] == CODE_OFF))
    else $error("controller not off without good cyclic exchange");

  chk_rsvd_zero: assert property (
    o_status_byte[STAT_RSVD_MSB:STAT_RSVD_LSB] == 6'h00)
    else $error("reserved status bits not zero");

  chk_reply_pulse: assert property (
    o_status_valid == $past(i_cmd_valid))
    else $error("status reply not paired with command");

  chk_busoff_quiet: assert property (
    o_status_byte[1:0] == CODE_BUS_OFF |-> !o_can_tx_en && !o_can_rx_en && o_pgn_hold)
    else $error("traffic enabled or data not held during bus off");

  chk_tx_code: assert property (
    o_can_tx_en |-> o_status_byte[1]) // Passive and active codes both have bit 1 set.
    else $error("transmit enabled outside passive or active state");

  chk_cmd_follow: assert property (
    i_cmd_valid && configured_ff && i_host_link_ok |=> ctl_on_ff == $past(i_cmd_byte[0]))
    else $error("command bit not taken");

  chk_host_loss: assert property (
    !i_host_link_ok && !i_config_load |=> !o_configured ##2
      (o_status_byte[1:0] == CODE_OFF))
    else $error("host link loss did not unconfigure and switch off");

  chk_cfg_load: assert property (
    i_config_load |=> o_configured)
    else $error("configuration load not taken");

  chk_switch_on: assert property (
    o_switch_fwd_en)
    else $error("switch forwarding dropped");

  chk_active_code: assert property (
    o_can_tx_en && $past(i_err_cnt) < ERR_PASSIVE_LIMIT |-> o_status_byte[1:0] == CODE_ACTIVE)
    else $error("error active not reported below threshold");

  chk_unconf_off: assert property (
    !o_configured |-> ##2 (o_status_byte[STAT_CODE_MSB:STAT_CODE_LSB] == CODE_OFF))
    else $error("unconfigured gateway not reported off");

  chk_run_joins: assert property (
    run_req |-> ##2 (o_can_rx_en || o_status_byte[1:0] == CODE_BUS_OFF))
    else $error("run request did not bring the controller onto the bus");

  chk_cfg_kept: assert property (
    o_configured && i_host_link_ok |=> o_configured)
    else $error("configuration lost while host link healthy");

  chk_off_no_hold: assert property (
    o_status_byte[1:0] != CODE_BUS_OFF |-> !o_pgn_hold)
    else $error("data held outside bus off");

endmodule : can_gateway_state_control

// *** sim/host_ctrl_model.sv ***
// Host controller model: issues one command byte per cyclic exchange.
// Assumes the bench sets the requested on bit and reserved bits as levels.
`timescale 1ns/1ns
module host_ctrl_model #(
  parameter int GAP = 4
) (
  input  wire logic       i_ref_clk,
  input  wire logic       i_sys_rst,
  input  wire logic       i_on,
  input  wire logic [6:0] i_rsvd,
  output logic [7:0]      o_cmd_byte,
  output logic            o_cmd_valid
);
  int cnt_ff;

  // Between exchanges the byte toggles so a stale value is never mistaken for a command.
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      cnt_ff      <= 0;
      o_cmd_valid <= 1'b0;
      o_cmd_byte  <= 8'h00;
    end else begin
      cnt_ff      <= (cnt_ff == GAP - 1) ? 0 : cnt_ff + 1;
      o_cmd_valid <= (cnt_ff == GAP - 1);
      o_cmd_byte  <= (cnt_ff == GAP - 1) ? {i_rsvd, i_on} : ~o_cmd_byte;
    end
  end
endmodule : host_ctrl_model

// *** sim/testbench.sv ***
// Self-checking bench for the gateway state control block.
// Assumes the host model supplies commands; the bench drives link and CAN core flags.
`timescale 1ns/1ns
module testbench;
  import can_state_pkg::*;
  logic                 ref_clk   = 1'b0;
  logic                 sys_rst   = 1'b1;
  logic                 host_on   = 1'b1;
  logic [6:0]           host_rsvd = 7'h00;
  logic                 exch_act  = 1'b1;
  logic                 prov_good = 1'b1;
  logic                 host_ok   = 1'b1;
  logic                 cfg_load  = 1'b0;
  logic                 sync_done = 1'b0;
  logic                 can_ok    = 1'b1;
  logic [ERR_CNT_W-1:0] err_cnt   = 9'h000;
  logic [7:0]           cmd_byte;
  logic                 cmd_valid;
  logic [7:0]           status_byte;
  logic                 status_valid;
  logic                 tx_en;
  logic                 rx_en;
  logic                 configured;
  logic                 pgn_hold;
  logic                 fwd_en;
  int                   num_errors  = 0;
  int                   check_count = 0;

  // Free-running 100 MHz clock.
  always #5 ref_clk = ~ref_clk;

  host_ctrl_model u_host (.i_ref_clk(ref_clk), .i_sys_rst(sys_rst), .i_on(host_on),
    .i_rsvd(host_rsvd), .o_cmd_byte(cmd_byte), .o_cmd_valid(cmd_valid));

  // A short sync timeout keeps the timeout scenario brief.
  can_gateway_state_control #(.SYNC_CYCLES(20)) u_dut (.i_ref_clk(ref_clk),
    .i_sys_rst(sys_rst), .i_cmd_byte(cmd_byte), .i_cmd_valid(cmd_valid),
    .i_exchange_active(exch_act), .i_provider_good(prov_good), .i_host_link_ok(host_ok),
    .i_config_load(cfg_load), .i_err_cnt(err_cnt), .i_sync_done(sync_done),
    .i_can_link_ok(can_ok), .o_status_byte(status_byte), .o_status_valid(status_valid),
    .o_can_tx_en(tx_en), .o_can_rx_en(rx_en), .o_configured(configured),
    .o_pgn_hold(pgn_hold), .o_switch_fwd_en(fwd_en));

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : tick

  // Sampling one step past the edge lets the design's updates land first.
  task automatic settle(input int n);
    tick(n);
    #1;
  endtask : settle

  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check_byte

  task automatic check_bit(input logic got, input logic exp, input string what);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask : check_bit

  task automatic expect_state(input logic [1:0] code, input logic tx, input logic rx);
    check_byte(status_byte, {6'h00, code}, "status");
    check_bit(tx_en, tx, "tx enable");
    check_bit(rx_en, rx, "rx enable");
  endtask : expect_state

  // A new on bit needs up to a full exchange gap plus the pipeline to show.
  task automatic set_on(input logic v);
    tick(1);
    host_on <= v;
    settle(12);
  endtask : set_on

  task automatic pulse_config();
    tick(1);
    cfg_load <= 1'b1;
    tick(1);
    cfg_load <= 1'b0;
    settle(12);
  endtask : pulse_config

  task automatic t_reset_state();
    expect_state(CODE_OFF, 1'b0, 1'b0);
    check_bit(fwd_en, 1'b1, "switch fwd");
    settle(12);
    expect_state(CODE_OFF, 1'b0, 1'b0);
    check_bit(configured, 1'b0, "configured");
    $display("test reset_state done");
  endtask : t_reset_state

  task automatic t_turn_on();
    pulse_config();
    check_bit(configured, 1'b1, "configured");
    expect_state(CODE_ACTIVE, 1'b0, 1'b1);
    tick(1);
    sync_done <= 1'b1;
    settle(4);
    expect_state(CODE_ACTIVE, 1'b1, 1'b1);
    repeat (8) begin
      settle(1);
      if (cmd_valid === 1'b1) break;
    end
    settle(1);
    check_bit(status_valid, 1'b1, "status valid");
    settle(1);
    check_bit(status_valid, 1'b0, "status valid end");
    $display("test turn_on done");
  endtask : t_turn_on

  task automatic t_err_levels();
    tick(1);
    err_cnt <= ERR_PASSIVE_LIMIT;
    settle(4);
    expect_state(CODE_PASSIVE, 1'b1, 1'b1);
    tick(1);
    err_cnt <= ERR_PASSIVE_LIMIT - 9'h001;
    settle(4);
    expect_state(CODE_ACTIVE, 1'b1, 1'b1);
    tick(1);
    err_cnt <= ERR_BUSOFF_LIMIT;
    settle(4);
    expect_state(CODE_PASSIVE, 1'b1, 1'b1);
    tick(1);
    err_cnt <= ERR_BUSOFF_LIMIT + 9'h001;
    settle(4);
    expect_state(CODE_BUS_OFF, 1'b0, 1'b0);
    check_bit(pgn_hold, 1'b1, "pgn hold");
    tick(1);
    err_cnt <= 9'h000;
    settle(8);
    expect_state(CODE_BUS_OFF, 1'b0, 1'b0);
    set_on(1'b0);
    expect_state(CODE_OFF, 1'b0, 1'b0);
    check_bit(pgn_hold, 1'b0, "pgn hold off");
    $display("test err_levels done");
  endtask : t_err_levels

  task automatic t_link_fail();
    set_on(1'b1);
    tick(1);
    can_ok <= 1'b0;
    settle(4);
    expect_state(CODE_BUS_OFF, 1'b0, 1'b0);
    check_bit(configured, 1'b1, "configured");
    check_bit(fwd_en, 1'b1, "switch fwd");
    tick(1);
    can_ok <= 1'b1;
    set_on(1'b0);
    $display("test link_fail done");
  endtask : t_link_fail

  task automatic t_sync_timeout();
    tick(1);
    sync_done <= 1'b0;
    set_on(1'b1);
    expect_state(CODE_ACTIVE, 1'b0, 1'b1);
    settle(40);
    expect_state(CODE_BUS_OFF, 1'b0, 1'b0);
    set_on(1'b0);
    expect_state(CODE_OFF, 1'b0, 1'b0);
    tick(1);
    sync_done <= 1'b1;
    $display("test sync_timeout done");
  endtask : t_sync_timeout

  task automatic t_provider();
    set_on(1'b1);
    tick(1);
    prov_good <= 1'b0;
    settle(12);
    expect_state(CODE_OFF, 1'b0, 1'b0);
    tick(1);
    prov_good <= 1'b1;
    exch_act  <= 1'b0;
    settle(12);
    expect_state(CODE_OFF, 1'b0, 1'b0);
    tick(1);
    exch_act <= 1'b1;
    settle(12);
    expect_state(CODE_ACTIVE, 1'b1, 1'b1);
    $display("test provider done");
  endtask : t_provider

  task automatic t_reserved();
    tick(1);
    host_rsvd <= 7'h7f;
    settle(12);
    expect_state(CODE_ACTIVE, 1'b1, 1'b1);
    set_on(1'b0);
    expect_state(CODE_OFF, 1'b0, 1'b0);
    tick(1);
    host_rsvd <= 7'h00;
    $display("test reserved done");
  endtask : t_reserved

  task automatic t_host_loss();
    set_on(1'b1);
    tick(1);
    host_ok <= 1'b0;
    settle(12);
    check_bit(configured, 1'b0, "configured");
    expect_state(CODE_OFF, 1'b0, 1'b0);
    tick(1);
    host_ok <= 1'b1;
    settle(12);
    expect_state(CODE_OFF, 1'b0, 1'b0);
    // A fresh load in the same cycle as a link drop must still configure the gateway.
    tick(1);
    host_ok  <= 1'b0;
    cfg_load <= 1'b1;
    tick(1);
    host_ok  <= 1'b1;
    cfg_load <= 1'b0;
    #1;
    check_bit(configured, 1'b1, "load over loss");
    pulse_config();
    expect_state(CODE_ACTIVE, 1'b1, 1'b1);
    $display("test host_loss done");
  endtask : t_host_loss

  task automatic report_and_stop();
    $display("Counts: %0d checks, %0d mismatches", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : report_and_stop

  // Main sequence: reset for 16 cycles, then every scenario in turn.
  initial begin
    tick(16);
    sys_rst <= 1'b0;
    settle(1);
    t_reset_state();
    t_turn_on();
    t_err_levels();
    t_link_fail();
    t_sync_timeout();
    t_provider();
    t_reserved();
    t_host_loss();
    report_and_stop();
  end

  // The tests need about 3.3 us; far more than that means something hung.
  initial begin
    #100_000;
    num_errors++;
    $display("CHECK FAILED t=%0t watchdog expired", $time);
    report_and_stop();
  end
endmodule : testbench
